// *** core/pwr_seq_pkg.sv ***
`default_nettype none
package pwr_seq_pkg;

    // Fixed target address; the shifted 8-bit write address is 0xD6.
    localparam logic [6:0]  TARGET_ADDR     = 7'h6B;
    // Value returned for any offset outside the register map.
    localparam logic [7:0]  UNMAPPED_READ   = 8'hFF;
    localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
    localparam logic [7:0]  PTR_STEP        = 8'h01;

    // Clock rate and the wake hold time.
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned WAKE_HOLD_US    = 1000;
    // A least time, so the count rounds up.
    localparam int unsigned WAKE_HOLD_CYCLES = (WAKE_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Measurement channels visited in turn by the converter.
    localparam int unsigned ADC_CHANNELS    = 8;
    localparam logic [2:0]  ADC_FIRST_CH    = 3'h0;
    localparam logic [2:0]  ADC_LAST_CH     = 3'(ADC_CHANNELS - 1);
    localparam logic [2:0]  ADC_CH_STEP     = 3'h1;

    typedef enum logic [2:0] {
        S_OFF,
        S_ADAPTER,
        S_BAT_CHECK,
        S_BAT_WAIT,
        S_BAT_ACTIVE,
        S_SHIP
    } mode_state_t;

    typedef enum logic [3:0] {
        I_IDLE,
        I_ADDR,
        I_ADDR_ACK,
        I_PTR,
        I_PTR_ACK,
        I_WR,
        I_WR_ACK,
        I_RD,
        I_RD_ACK
    } i2c_state_t;

endpackage : pwr_seq_pkg
`default_nettype wire

// *** core/i2c_register_target.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2c_register_target (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_wr_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_hit_i
);

    pwr_seq_pkg::i2c_state_t state_q;
    logic                    scl_q;
    logic                    sda_q;
    logic [7:0]              shift_q;
    logic [3:0]              cnt_q;
    logic                    rw_q;
    logic [7:0]              ptr_q;
    logic                    oe_q;
    logic                    wr_q;
    logic [7:0]              wdata_q;

    // Bus events are found from the previous pin levels.
    wire       scl_rise   = scl_i & ~scl_q;
    wire       scl_fall   = ~scl_i & scl_q;
    wire       start_cond = scl_i & scl_q & sda_q & ~sda_i;
    wire       stop_cond  = scl_i & scl_q & ~sda_q & sda_i;
    wire       byte_done  = (cnt_q == pwr_seq_pkg::BITS_PER_BYTE);
    wire       addr_match = (shift_q[7:1] == pwr_seq_pkg::TARGET_ADDR);
    wire [7:0] read_byte  = reg_hit_i ? reg_rdata_i : pwr_seq_pkg::UNMAPPED_READ;
    wire [7:0] ptr_next   = ptr_q + pwr_seq_pkg::PTR_STEP;

    // The pin is open drain: the level is always low and only the enable moves.
    assign sda_o       = 1'b0;
    assign sda_oe_o    = oe_q;
    assign reg_addr_o  = ptr_q;
    assign reg_wdata_o = wdata_q;
    assign reg_wr_o    = wr_q;

    // Data is taken on the rising edge of the clock line and changed on the falling one.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_q <= pwr_seq_pkg::I_IDLE;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            shift_q <= 8'h00;
            cnt_q   <= 4'h0;
            rw_q    <= 1'b0;
            ptr_q   <= 8'h00;
            oe_q    <= 1'b0;
            wr_q    <= 1'b0;
            wdata_q <= 8'h00;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            wr_q  <= 1'b0;
            if (start_cond) begin
                state_q <= pwr_seq_pkg::I_ADDR;
                cnt_q   <= 4'h0;
                oe_q    <= 1'b0;
            end else if (stop_cond) begin
                state_q <= pwr_seq_pkg::I_IDLE;
                oe_q    <= 1'b0;
            end else if (scl_rise) begin
                if (state_q == pwr_seq_pkg::I_ADDR || state_q == pwr_seq_pkg::I_PTR ||
                    state_q == pwr_seq_pkg::I_WR) begin
                    shift_q <= {shift_q[6:0], sda_i};
                    cnt_q   <= cnt_q + 4'h1;
                end else if (state_q == pwr_seq_pkg::I_RD_ACK && sda_i) begin
                    state_q <= pwr_seq_pkg::I_IDLE;
                end
            end else if (scl_fall) begin
                unique case (state_q)
                    pwr_seq_pkg::I_IDLE: begin
                    end
                    pwr_seq_pkg::I_ADDR: begin
                        if (byte_done) begin
                            oe_q    <= addr_match;
                            rw_q    <= shift_q[0];
                            state_q <= addr_match ? pwr_seq_pkg::I_ADDR_ACK : pwr_seq_pkg::I_IDLE;
                        end
                    end
                    pwr_seq_pkg::I_PTR: begin
                        if (byte_done) begin
                            oe_q    <= 1'b1;
                            ptr_q   <= shift_q;
                            state_q <= pwr_seq_pkg::I_PTR_ACK;
                        end
                    end
                    pwr_seq_pkg::I_WR: begin
                        if (byte_done) begin
                            oe_q    <= 1'b1;
                            wr_q    <= 1'b1;
                            wdata_q <= shift_q;
                            state_q <= pwr_seq_pkg::I_WR_ACK;
                        end
                    end
                    pwr_seq_pkg::I_ADDR_ACK, pwr_seq_pkg::I_RD_ACK: begin
                        if (rw_q) begin
                            oe_q    <= ~read_byte[7];
                            shift_q <= read_byte;
                            ptr_q   <= ptr_next;
                            cnt_q   <= 4'h1;
                            state_q <= pwr_seq_pkg::I_RD;
                        end else begin
                            oe_q    <= 1'b0;
                            cnt_q   <= 4'h0;
                            state_q <= pwr_seq_pkg::I_PTR;
                        end
                    end
                    pwr_seq_pkg::I_PTR_ACK, pwr_seq_pkg::I_WR_ACK: begin
                        oe_q    <= 1'b0;
                        cnt_q   <= 4'h0;
                        ptr_q   <= (state_q == pwr_seq_pkg::I_WR_ACK) ? ptr_next : ptr_q;
                        state_q <= pwr_seq_pkg::I_WR;
                    end
                    pwr_seq_pkg::I_RD: begin
                        if (byte_done) begin
                            oe_q    <= 1'b0;
                            state_q <= pwr_seq_pkg::I_RD_ACK;
                        end else begin
                            oe_q    <= ~shift_q[6];
                            shift_q <= {shift_q[6:0], 1'b0};
                            cnt_q   <= cnt_q + 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    // Acknowledging an address means the received address was our own.
    property p_ack_own_addr;
        @(posedge clk_i) disable iff (!reset_n_i)
        state_q == pwr_seq_pkg::I_ADDR_ACK |-> oe_q && shift_q[7:1] == pwr_seq_pkg::TARGET_ADDR;
    endproperty
    a_ack_own_addr: assert property (p_ack_own_addr) else $error("Address acknowledged that is not ours.");

    // A read of an unmapped offset loads all ones into the shifter.
    property p_unmapped_reads_ones;
        @(posedge clk_i) disable iff (!reset_n_i)
        (scl_fall && state_q == pwr_seq_pkg::I_ADDR_ACK && rw_q && !reg_hit_i)
        |=> shift_q == pwr_seq_pkg::UNMAPPED_READ && state_q == pwr_seq_pkg::I_RD;
    endproperty
    a_unmapped_reads_ones: assert property (p_unmapped_reads_ones) else $error("Unmapped read gave no FF.");

endmodule : i2c_register_target
`default_nettype wire

// *** core/charger_power_mode_sequencer.sv ***
// Notes on behaviour
// - An input above its undervoltage level always puts the device in adapter mode.
// - In adapter mode the converter stays enabled and steps through every channel without pause.
// - In adapter mode a valid input above the dynamic power level feeds the system rail.
// - In adapter mode, with charging enabled, the battery charges until termination and then stops.
// - Inserting an input above its undervoltage level wakes the device and raises the always-on rail.
// - The system rail joins the input only above battery plus sleep offset and below overvoltage; charging needs the dynamic power level.
// - A battery inserted with no valid input leads straight to ship mode unless the wake button is held low.
// - On battery insertion the always-on rail rises briefly to sample the button, and drops at once into ship mode if it reads high.
// - A low button on battery insertion starts a wake timer, and the rails come up only if it stays low past the hold time.
// - The serial target answers only at the fixed 7-bit address 0x6B.
// - Reads of offsets outside the register map return FF.
`timescale 1ns/10ps
`default_nettype none
module charger_power_mode_sequencer #(
    parameter int unsigned WAKE_HOLD_CYCLES = pwr_seq_pkg::WAKE_HOLD_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       in_above_uvlo_i,
    input  wire logic       in_above_bat_slp_i,
    input  wire logic       in_above_ovp_i,
    input  wire logic       in_above_dpm_i,
    input  wire logic       bat_above_uvlo_i,
    input  wire logic       wake_button_n_i,
    input  wire logic       charge_enable_i,
    input  wire logic       charge_done_i,
    output logic            adapter_mode_o,
    output logic            adc_enable_o,
    output logic [2:0]      adc_channel_o,
    output logic            always_on_rail_o,
    output logic            system_rail_from_input_o,
    output logic            rails_on_o,
    output logic            charging_o,
    output logic            ship_mode_o,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_wr_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_hit_i
);

    pwr_seq_pkg::mode_state_t state_q;
    pwr_seq_pkg::mode_state_t state_d;
    logic                     bat_prev_q;
    logic [31:0]              wait_cnt_q;
    logic                     done_q;
    logic [2:0]               channel_q;
    logic                     adapter_q;
    logic                     adc_en_q;
    logic                     aon_q;
    logic                     rail_in_q;
    logic                     rails_q;
    logic                     charge_q;
    logic                     ship_q;

    // Decode of insertion, timer and the conditions that gate the rail and the charger.
    wire        bat_inserted = bat_above_uvlo_i & ~bat_prev_q;
    wire        wait_done    = (wait_cnt_q == WAKE_HOLD_CYCLES);
    wire        adapter_next = (state_d == pwr_seq_pkg::S_ADAPTER);
    wire        input_good   = in_above_bat_slp_i & ~in_above_ovp_i;
    wire        rail_in_d    = adapter_next & input_good & in_above_dpm_i;
    wire        done_d       = adapter_next & charge_enable_i & (done_q | (charge_q & charge_done_i));
    wire        charge_d     = rail_in_d & charge_enable_i & ~done_d;
    wire [2:0]  channel_d    = !adapter_next ? pwr_seq_pkg::ADC_FIRST_CH :
                               (channel_q == pwr_seq_pkg::ADC_LAST_CH) ? pwr_seq_pkg::ADC_FIRST_CH :
                               channel_q + pwr_seq_pkg::ADC_CH_STEP;
    wire [31:0] wait_cnt_d   = (state_q == pwr_seq_pkg::S_BAT_WAIT) ? wait_cnt_q + 32'h1 : 32'h0;

    // A live input overrides every battery-side state, so a wake by supply cannot be missed.
    always_comb begin
        state_d = state_q;
        if (in_above_uvlo_i) begin
            state_d = pwr_seq_pkg::S_ADAPTER;
        end else begin
            unique case (state_q)
                pwr_seq_pkg::S_OFF: begin
                    if (bat_inserted) begin
                        state_d = pwr_seq_pkg::S_BAT_CHECK;
                    end
                end
                pwr_seq_pkg::S_ADAPTER: begin
                    state_d = bat_above_uvlo_i ? pwr_seq_pkg::S_BAT_ACTIVE : pwr_seq_pkg::S_OFF;
                end
                pwr_seq_pkg::S_BAT_CHECK: begin
                    state_d = wake_button_n_i ? pwr_seq_pkg::S_SHIP : pwr_seq_pkg::S_BAT_WAIT;
                end
                pwr_seq_pkg::S_BAT_WAIT: begin
                    if (wake_button_n_i) begin
                        state_d = pwr_seq_pkg::S_SHIP;
                    end else if (wait_done) begin
                        state_d = pwr_seq_pkg::S_BAT_ACTIVE;
                    end
                end
                pwr_seq_pkg::S_BAT_ACTIVE, pwr_seq_pkg::S_SHIP: begin
                    if (!bat_above_uvlo_i) begin
                        state_d = pwr_seq_pkg::S_OFF;
                    end
                end
            endcase
        end
    end

    // State, timer and latches.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_q    <= pwr_seq_pkg::S_OFF;
            bat_prev_q <= 1'b0;
            wait_cnt_q <= 32'h0;
            done_q     <= 1'b0;
            channel_q  <= pwr_seq_pkg::ADC_FIRST_CH;
        end else begin
            state_q    <= state_d;
            bat_prev_q <= bat_above_uvlo_i;
            wait_cnt_q <= wait_cnt_d;
            done_q     <= done_d;
            channel_q  <= channel_d;
        end
    end

    // Outputs are registered from the next state so they line up with the state register.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            adapter_q <= 1'b0;
            adc_en_q  <= 1'b0;
            aon_q     <= 1'b0;
            rail_in_q <= 1'b0;
            rails_q   <= 1'b0;
            charge_q  <= 1'b0;
            ship_q    <= 1'b0;
        end else begin
            adapter_q <= adapter_next;
            adc_en_q  <= adapter_next;
            aon_q     <= (state_d != pwr_seq_pkg::S_OFF) && (state_d != pwr_seq_pkg::S_SHIP);
            rail_in_q <= rail_in_d;
            rails_q   <= (state_d == pwr_seq_pkg::S_BAT_ACTIVE);
            charge_q  <= charge_d;
            ship_q    <= (state_d == pwr_seq_pkg::S_SHIP);
        end
    end

    assign adapter_mode_o           = adapter_q;
    assign adc_enable_o             = adc_en_q;
    assign adc_channel_o            = channel_q;
    assign always_on_rail_o         = aon_q;
    assign system_rail_from_input_o = rail_in_q;
    assign rails_on_o               = rails_q;
    assign charging_o               = charge_q;
    assign ship_mode_o              = ship_q;

    // Writes are passed on without a map check; the host keeps clear of reserved offsets.
    i2c_register_target u_target (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .scl_i       (scl_i),
        .sda_i       (sda_i),
        .sda_o       (sda_o),
        .sda_oe_o    (sda_oe_o),
        .reg_addr_o  (reg_addr_o),
        .reg_wdata_o (reg_wdata_o),
        .reg_wr_o    (reg_wr_o),
        .reg_rdata_i (reg_rdata_i),
        .reg_hit_i   (reg_hit_i)
    );

    // Helper logic: consecutive low cycles of the button, saturating, and the waiting flag.
    logic [31:0] low_cnt_q;
    wire         in_wait     = (state_q == pwr_seq_pkg::S_BAT_WAIT);
    wire [2:0]   ch_expected = (channel_q == pwr_seq_pkg::ADC_LAST_CH) ? pwr_seq_pkg::ADC_FIRST_CH :
                               channel_q + pwr_seq_pkg::ADC_CH_STEP;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            low_cnt_q <= 32'h0;
        end else begin
            low_cnt_q <= wake_button_n_i ? 32'h0 : ((&low_cnt_q) ? low_cnt_q : low_cnt_q + 32'h1);
        end
    end

    sequence s_bat_insert;
        $rose(bat_above_uvlo_i) && !in_above_uvlo_i && state_q == pwr_seq_pkg::S_OFF;
    endsequence

    sequence s_button_high_check;
        s_bat_insert ##1 (wake_button_n_i && !in_above_uvlo_i);
    endsequence

    property p_adapter_entry;
        @(posedge clk_i) disable iff (!reset_n_i)
        in_above_uvlo_i |=> adapter_mode_o && adc_enable_o;
    endproperty
    a_adapter_entry: assert property (p_adapter_entry) else $error("No adapter mode with input valid.");

    property p_channel_cycle;
        @(posedge clk_i) disable iff (!reset_n_i)
        (adapter_mode_o && in_above_uvlo_i) |=> adc_enable_o && adc_channel_o == $past(ch_expected);
    endproperty
    a_channel_cycle: assert property (p_channel_cycle) else $error("Converter channel did not advance.");

    property p_rail_from_input;
        @(posedge clk_i) disable iff (!reset_n_i)
        (in_above_uvlo_i && in_above_bat_slp_i && !in_above_ovp_i && in_above_dpm_i)
        |=> system_rail_from_input_o;
    endproperty
    a_rail_from_input: assert property (p_rail_from_input) else $error("System rail not fed by input.");

    property p_stop_at_done;
        @(posedge clk_i) disable iff (!reset_n_i)
        (charging_o && charge_done_i) ##1 (in_above_uvlo_i && charge_enable_i) [*2] |=> !charging_o;
    endproperty
    a_stop_at_done: assert property (p_stop_at_done) else $error("Charging went on after termination.");

    property p_wake_on_input;
        @(posedge clk_i) disable iff (!reset_n_i)
        $rose(in_above_uvlo_i) |=> always_on_rail_o;
    endproperty
    a_wake_on_input: assert property (p_wake_on_input) else $error("Always-on rail not raised by input.");

    property p_rail_window;
        @(posedge clk_i) disable iff (!reset_n_i)
        system_rail_from_input_o |-> $past(in_above_bat_slp_i) && !$past(in_above_ovp_i);
    endproperty
    a_rail_window: assert property (p_rail_window) else $error("System rail joined input out of window.");

    property p_ship_on_high_button;
        @(posedge clk_i) disable iff (!reset_n_i)
        s_button_high_check |=> ship_mode_o && !always_on_rail_o && !rails_on_o;
    endproperty
    a_ship_on_high_button: assert property (p_ship_on_high_button) else $error("No ship mode on insertion.");

    property p_brief_check;
        @(posedge clk_i) disable iff (!reset_n_i)
        s_bat_insert |=> always_on_rail_o && !ship_mode_o;
    endproperty
    a_brief_check: assert property (p_brief_check) else $error("Always-on rail not raised to check button.");

    property p_wake_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        ($rose(rails_on_o) && $past(in_wait)) |-> low_cnt_q > WAKE_HOLD_CYCLES;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("Rails up before the wake hold time.");

endmodule : charger_power_mode_sequencer
`default_nettype wire

// *** verification/i2c_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host side of the serial bus plus the wake button; the data line is open drain with a pull-up.
module i2c_host_model (
    input  wire logic clk_i,
    input  wire logic sda_line_i,
    output logic      scl_o,
    output logic      sda_drv_o,
    output logic      button_n_o
);
    // Bus idles released and the button rests unpressed.
    initial begin
        scl_o = 1'b1;
        sda_drv_o = 1'b1;
        button_n_o = 1'b1;
    end
    // Four clocks per phase keeps clear of the one-clock minimum the target needs.
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask : half
    task automatic press(input logic level);
        button_n_o = level;
    endtask : press
    task automatic start();
        sda_drv_o = 1'b1;
        scl_o = 1'b1;
        half();
        sda_drv_o = 1'b0;
        half();
        scl_o = 1'b0;
        half();
    endtask : start
    task automatic stop();
        sda_drv_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_drv_o = 1'b1;
        half();
    endtask : stop
    // Sends MSB first; a byte of all ones leaves the line free so the target can send. The ninth bit is
    // always released, so a read byte is answered with a nack and the read ends there.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_drv_o = tx[i];
            half();
            scl_o = 1'b1;
            half();
            rx[i] = sda_line_i;
            scl_o = 1'b0;
        end
        sda_drv_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        ack = ~sda_line_i;
        scl_o = 1'b0;
    endtask : xfer
endmodule : i2c_host_model
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int unsigned HOLD = 20;
    logic       clk_i, reset_n_i, uvlo, slp, ovp, dpm, bat, ce, done, scl, host_sda, button_n, sda_line;
    logic       adapter, adc_en, aon, sys_rail, rails_on, charging, ship, sda_o, sda_oe, reg_wr, ack;
    logic [2:0] channel, ch;
    logic [7:0] reg_addr, reg_wdata, rx, wr_addr, wr_data;
    int         err_count, comparisons, cycles, wr_count;

    // Open-drain line with pull-up: low whenever either party pulls it.
    assign sda_line = (sda_oe ? sda_o : 1'b1) & host_sda;

    charger_power_mode_sequencer #(.WAKE_HOLD_CYCLES(HOLD)) dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .in_above_uvlo_i(uvlo), .in_above_bat_slp_i(slp),
        .in_above_ovp_i(ovp), .in_above_dpm_i(dpm), .bat_above_uvlo_i(bat), .wake_button_n_i(button_n),
        .charge_enable_i(ce), .charge_done_i(done), .adapter_mode_o(adapter), .adc_enable_o(adc_en),
        .adc_channel_o(channel), .always_on_rail_o(aon), .system_rail_from_input_o(sys_rail),
        .rails_on_o(rails_on), .charging_o(charging), .ship_mode_o(ship), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
        .reg_rdata_i(8'h5A), .reg_hit_i(reg_addr < 8'h03));

    i2c_host_model host (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_drv_o(host_sda),
        .button_n_o(button_n));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Write pulses are caught mid-cycle, away from the edge that launches them.
    always @(negedge clk_i) begin
        if (reg_wr === 1'b1) begin
            wr_count++;
            wr_addr = reg_addr;
            wr_data = reg_wdata;
        end
    end

    // Hang guard, far above the roughly 1,200 cycles the run needs.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask : step

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic adapter_mode();
        {uvlo, slp, dpm, ce} = 4'hF;
        step(1);
        check(adapter, 1, "adapter mode");
        check(adc_en, 1, "converter on");
        check(aon, 1, "always-on rail");
        check(sys_rail, 1, "system rail fed");
        check(charging, 1, "charging");
        ch = channel;
        for (int i = 1; i <= 8; i++) begin
            step(1);
            check(channel, 3'(ch + i), "channel step");
        end
        done = 1'b1;
        step(1);
        check(charging, 0, "stop at end");
        done = 1'b0;
        step(2);
        check(charging, 0, "stays stopped");
        ovp = 1'b1;
        step(1);
        check(sys_rail, 0, "overvoltage");
        {ovp, slp} = 2'h0;
        step(1);
        check(sys_rail, 0, "below battery");
        uvlo = 1'b0;
        step(1);
        check(adapter, 0, "adapter left");
    endtask : adapter_mode

    task automatic battery_modes();
        bat = 1'b1;
        step(1);
        check(aon, 1, "button sample");
        step(1);
        check(ship, 1, "ship entry");
        check(aon, 0, "rail dropped");
        bat = 1'b0;
        step(2);
        host.press(1'b0);
        bat = 1'b1;
        step(1);
        check(aon, 1, "rail for timer");
        step(HOLD);
        check(rails_on, 0, "too early");
        step(3);
        check(rails_on, 1, "rails up");
        check(ship, 0, "no ship");
        uvlo = 1'b1;
        step(1);
        check(adapter, 1, "input overrides");
        {uvlo, bat} = 2'h0;
        host.press(1'b1);
        step(2);
        // A button let go part way through the wake hold must not bring the rails up.
        bat = 1'b1;
        host.press(1'b0);
        step(5);
        host.press(1'b1);
        step(1);
        check(ship, 1, "early release");
        check(rails_on, 0, "no rails on early release");
        bat = 1'b0;
        step(2);
    endtask : battery_modes

    task automatic serial_target();
        host.start();
        host.xfer(8'hD6, rx, ack);
        check(ack, 1, "own address");
        host.xfer(8'h02, rx, ack);
        host.xfer(8'hA5, rx, ack);
        host.stop();
        check(8'(wr_count), 1, "write count");
        check(wr_addr, 8'h02, "write offset");
        check(wr_data, 8'hA5, "write data");
        host.start();
        host.xfer(8'hD4, rx, ack);
        check(ack, 0, "other address");
        host.xfer(8'h02, rx, ack);
        host.xfer(8'h3C, rx, ack);
        host.stop();
        check(8'(wr_count), 1, "ignored write");
        host.start();
        host.xfer(8'hD6, rx, ack);
        host.xfer(8'h80, rx, ack);
        host.stop();
        host.start();
        host.xfer(8'hD7, rx, ack);
        check(ack, 1, "read address");
        host.xfer(8'hFF, rx, ack);
        host.stop();
        check(rx, 8'hFF, "unmapped read");
        // A mapped offset must give the register value, so the all-ones above is not just a released line.
        host.start();
        host.xfer(8'hD6, rx, ack);
        host.xfer(8'h01, rx, ack);
        host.stop();
        host.start();
        host.xfer(8'hD7, rx, ack);
        check(ack, 1, "mapped read address");
        host.xfer(8'hFF, rx, ack);
        host.stop();
        check(rx, 8'h5A, "mapped read");
    endtask : serial_target

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    // Everything quiet and in reset from time zero; reset is released after five clocks.
    initial begin
        {reset_n_i, uvlo, slp, ovp, dpm, bat, ce, done} = 8'h00;
        {err_count, comparisons, cycles, wr_count} = '0;
        step(5);
        reset_n_i = 1'b1;
        step(2);
        adapter_mode();
        battery_modes();
        serial_target();
        results();
    end
endmodule : tb_top
`default_nettype wire
